// ==== rtl/brd_decoder.sv ====
// Module: first-level and internal memory address decoder with boot alias and remap
`timescale 1ns/1ps
`default_nettype none
module brd_decoder #(
  parameter int NUM_MST = brd_pkg::NUM_MST
) (
  input  wire logic                 clk,             // Matrix clock
  input  wire logic                 srst,            // Sync reset, high
  input  wire logic                 boot_select_pin, // Boot strap pin
  input  wire logic [NUM_MST-1:0]   per_master_remap_bit, // Remap per master
  input  wire logic                 tcm_cfg_we,      // Load coupled sizes
  input  wire brd_pkg::brd_tcm_s    tcm_size_config, // New coupled sizes
  input  wire brd_pkg::brd_req_s    req,             // Master request
  output brd_pkg::brd_route_s       route,           // Registered route
  output logic                      route_valid,     // Route valid
  output logic                      bus_error,       // Error response
  output logic                      boot_sel_cap,    // Captured strap
  output brd_pkg::brd_tcm_s         tcm_size,        // Active sizes
  output brd_pkg::brd_smc_s         smc_boot_cfg     // Chip select 0 reset mode
);
  typedef enum logic [1:0] {BRD_S_RESET, BRD_S_SAMPLE, BRD_S_RUN} brd_phase_e;

  typedef struct packed {
    logic               pin_m;
    logic               pin_s;
    brd_phase_e         phase;
    logic               boot_sel;
    brd_pkg::brd_tcm_s  tcm;
    brd_pkg::brd_route_s route;
    logic               vld;
    logic               err;
    brd_pkg::brd_smc_s  static_mem_ctrl;
  } brd_state_s;

  brd_state_s st;
  brd_state_s next_st;

  logic [3:0]  bank;
  logic [7:0]  region;
  logic [1:0]  slot;
  logic        blk_hit;
  logic        ram_hit;
  logic [1:0]  blk_num;
  logic        remap;
  logic        cpu_mst;
  logic [7:0]  eff_region;

  assign bank   = req.addr[31:brd_pkg::BANK_LSB];
  assign region = req.addr[27:brd_pkg::REG_LSB];
  assign slot   = req.addr[brd_pkg::RAM_AW-1:brd_pkg::BLK_LSB];
  // Only the low 64 KB of a region is backed; the rest of the 1 MB is unbacked
  assign ram_hit = blk_hit && (req.addr[19:brd_pkg::RAM_AW] == '0);
  assign remap  = (req.master < 3'(NUM_MST)) ? per_master_remap_bit[req.master] : 1'b0;
  assign cpu_mst = (req.master == 3'(brd_pkg::MST_INSTR)) || (req.master == 3'(brd_pkg::MST_DATA));
  // alias of general area, processor masters only
  assign eff_region = (region == brd_pkg::REG_ALIAS && remap && cpu_mst) ? brd_pkg::REG_GEN
                                                                         : region;

  brd_blkmap u_blkmap (
    .region    (eff_region),
    .slot      (slot),
    .instruction_coupled_area_size (st.tcm.instruction_coupled_area_size),
    .data_coupled_area_size (st.tcm.data_coupled_area_size),
    .hit       (blk_hit),
    .block     (blk_num)
  );

  always_comb begin
    next_st = st;
    // Two-flop sync of the strap pin
    next_st.pin_m = boot_select_pin;
    next_st.pin_s = st.pin_m;
    next_st.vld = 1'b0;
    next_st.err = 1'b0;
    next_st.route = '0;
    case (st.phase)
      BRD_S_RESET: begin
        next_st.phase = BRD_S_SAMPLE;
      end
      BRD_S_SAMPLE: begin
        next_st.boot_sel = st.pin_s;
        next_st.phase = BRD_S_RUN;
      end
      default: begin
        next_st.phase = BRD_S_RUN;
      end
    endcase
    next_st.static_mem_ctrl.byte_mode = brd_pkg::SMC_BYTE_SELECT;
    next_st.static_mem_ctrl.bus_width = brd_pkg::SMC_BUS_16;
    next_st.static_mem_ctrl.strobe_by_cs = 1'b1;
    if (tcm_cfg_we) begin
      next_st.tcm.instruction_coupled_area_size = (tcm_size_config.instruction_coupled_area_size > brd_pkg::SZ_32K)
                              ? brd_pkg::SZ_32K : tcm_size_config.instruction_coupled_area_size;
      next_st.tcm.data_coupled_area_size = (tcm_size_config.data_coupled_area_size > brd_pkg::SZ_32K)
                              ? brd_pkg::SZ_32K : tcm_size_config.data_coupled_area_size;
    end
    if (req.valid && st.phase == BRD_S_RUN) begin
      next_st.vld = 1'b1;
      next_st.route.offset = req.addr[15:0];
      if (bank == brd_pkg::BANK_INT) begin
        if (region == brd_pkg::REG_ALIAS) begin
          if (remap && cpu_mst) begin
            next_st.route.target = ram_hit ? brd_pkg::BRD_T_RAM : brd_pkg::BRD_T_ERR;
            next_st.route.ram_block = blk_num;
          end else if (st.boot_sel) begin
            next_st.route.target = brd_pkg::BRD_T_ROM;
          end else begin
            next_st.route.target = brd_pkg::BRD_T_EXT;
            next_st.route.ext_bank = brd_pkg::BANK_EXT_LO;
          end
        end else if (region == brd_pkg::REG_ROM) begin
          next_st.route.target = (req.addr[19:brd_pkg::ROM_AW] == '0)
                                 ? brd_pkg::BRD_T_ROM : brd_pkg::BRD_T_ERR;
        end else if (region == brd_pkg::REG_INSTRUCTION_COUPLED_AREA || region == brd_pkg::REG_DATA_COUPLED_AREA
                     || region == brd_pkg::REG_GEN) begin
          next_st.route.target = ram_hit ? brd_pkg::BRD_T_RAM : brd_pkg::BRD_T_ERR;
          next_st.route.ram_block = blk_num;
        end else begin
          next_st.route.target = brd_pkg::BRD_T_ERR;
        end
      end else if (bank >= brd_pkg::BANK_EXT_LO && bank <= brd_pkg::BANK_EXT_HI) begin
        next_st.route.target = brd_pkg::BRD_T_EXT;
        next_st.route.ext_bank = bank;
      end else if (bank == brd_pkg::BANK_PERIPH) begin
        next_st.route.target = brd_pkg::BRD_T_PERIPH;
      end else begin
        next_st.route.target = brd_pkg::BRD_T_ERR;
      end
      next_st.err = (next_st.route.target == brd_pkg::BRD_T_ERR);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st <= '0;
      // Strap synchroniser keeps running so the capture sees the real pin
      st.pin_m <= next_st.pin_m;
      st.pin_s <= next_st.pin_s;
    end else begin
      st <= next_st;
    end
  end

  // route ready one cycle after request
  assign route        = st.route;
  assign route_valid  = st.vld;
  assign bus_error    = st.err;
  assign boot_sel_cap = st.boot_sel;
  assign tcm_size     = st.tcm;
  assign smc_boot_cfg = st.static_mem_ctrl;
endmodule
`default_nettype wire

// ==== rtl/brd_pkg.sv ====
// Package: constants and carrier types for the boot remap address decoder
// Operation
// - Sixteen 256 MB banks chosen by address bits 31..28.
// - Banks 1 to 8 go to the external bus interface, eight chip selects.
// - Bank 0 is internal memory; second stage resolves a 1 MB region.
// - Bank 15 goes to the peripheral bridge.
// - Unassigned areas answer with an error response.
// - Each master has its own remap bit; for processor masters it picks zero with boot pin.
// - No remap and boot pin high: ROM appears at zero.
// - No remap and boot pin low: external chip select zero at zero.
// - Alias region 0x0 to 0x000F_FFFF follows boot pin and remap.
// - Boot pin captured at reset and never sampled again.
// - Before remap, general SRAM only at 0x0030_0000, for all masters.
// - After remap, general SRAM also at zero for processor masters only.
// - ROM always decoded at its fixed base.
// - Every block stays at its base; only the zero alias changes.
// - Instruction area visible on the bus at 0x0010_0000.
// - Data area visible on the bus at 0x0020_0000.
// - Coupled areas sized 0, 16K or 32K; general gets the rest.
// - After reset all four blocks general, coupled areas zero-sized.
// - Instruction uses 1 then 0, data 3 then 2, general descends.
// - SRAM single-cycle on bus and on coupled port.
// - Boot from chip select zero: byte select, 16-bit, strobes by select.
package brd_pkg;
  localparam int ADDR_W   = 32;
  localparam int BANK_LSB = 28;
  localparam int NUM_MST  = 6;
  localparam int MST_INSTR = 4;
  localparam int MST_DATA  = 5;
  localparam logic [3:0] BANK_INT    = 4'h0;
  localparam logic [3:0] BANK_EXT_LO = 4'h1;
  localparam logic [3:0] BANK_EXT_HI = 4'h8;
  localparam logic [3:0] BANK_PERIPH = 4'hf;
  localparam int REG_LSB  = 20;
  localparam logic [7:0] REG_ALIAS = 8'h00;
  localparam logic [7:0] REG_INSTRUCTION_COUPLED_AREA  = 8'h01;
  localparam logic [7:0] REG_DATA_COUPLED_AREA  = 8'h02;
  localparam logic [7:0] REG_GEN   = 8'h03;
  localparam logic [7:0] REG_ROM   = 8'h04;
  localparam int BLK_LSB  = 14;
  localparam int BLK_W    = 14;
  localparam int RAM_AW   = 16;
  localparam int ROM_AW   = 15;
  localparam logic [1:0] SZ_0K   = 2'h0;
  localparam logic [1:0] SZ_16K  = 2'h1;
  localparam logic [1:0] SZ_32K  = 2'h2;
  localparam logic [1:0] SMC_BYTE_SELECT = 2'h1;
  localparam logic [1:0] SMC_BUS_16      = 2'h1;

  typedef enum logic [2:0] {
    BRD_T_NONE, BRD_T_ROM, BRD_T_RAM, BRD_T_EXT, BRD_T_PERIPH, BRD_T_ERR
  } brd_target_e;

  typedef struct packed {
    logic        valid;
    logic [2:0]  master;
    logic [31:0] addr;
  } brd_req_s;

  typedef struct packed {
    brd_target_e target;
    logic [1:0]  ram_block;
    logic [15:0] offset;
    logic [3:0]  ext_bank;
  } brd_route_s;

  typedef struct packed {
    logic [1:0] instruction_coupled_area_size;
    logic [1:0] data_coupled_area_size;
  } brd_tcm_s;

  typedef struct packed {
    logic [1:0] byte_mode;
    logic [1:0] bus_width;
    logic       strobe_by_cs;
  } brd_smc_s;
endpackage

// ==== rtl/brd_blkmap.sv ====
// Module: maps a decoded area and 16 KB slot onto one physical SRAM block
`timescale 1ns/1ps
`default_nettype none
module brd_blkmap (
  input  wire logic [7:0] region,      // Decoded 1 MB region
  input  wire logic [1:0] slot,        // 16 KB slot in region
  input  wire logic [1:0] instruction_coupled_area_size,   // Instruction area size
  input  wire logic [1:0] data_coupled_area_size,   // Data area size
  output logic            hit,         // Slot backed by a block
  output logic [1:0]      block        // Physical block number
);
  logic [2:0] n_i;
  logic [2:0] n_d;
  logic [2:0] n_g;
  logic [3:0] used;
  logic [2:0] cnt;

  always_comb begin
    n_i = (instruction_coupled_area_size == brd_pkg::SZ_32K) ? 3'd2 : (instruction_coupled_area_size == brd_pkg::SZ_16K) ? 3'd1 : 3'd0;
    n_d = (data_coupled_area_size == brd_pkg::SZ_32K) ? 3'd2 : (data_coupled_area_size == brd_pkg::SZ_16K) ? 3'd1 : 3'd0;
    n_g = 3'd4 - n_i - n_d;
    hit = 1'b0;
    block = 2'd0;
    // Blocks held by the coupled areas, one bit per physical block
    used = {n_d != 3'd0, n_d == 3'd2, n_i != 3'd0, n_i == 3'd2};
    cnt = 3'd0;
    if (region == brd_pkg::REG_INSTRUCTION_COUPLED_AREA) begin
      hit = ({1'b0, slot} < n_i);
      block = 2'd1 - slot;
    end else if (region == brd_pkg::REG_DATA_COUPLED_AREA) begin
      hit = ({1'b0, slot} < n_d);
      block = 2'd3 - slot;
    end else if (region == brd_pkg::REG_GEN || region == brd_pkg::REG_ALIAS) begin
      hit = ({1'b0, slot} < n_g);
      // Free blocks fill the general area from the top block down, gaps skipped
      for (int b = 3; b >= 0; b--) begin
        if (!used[b]) begin
          if (cnt == {1'b0, slot})
            block = 2'(b);
          cnt = cnt + 3'd1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== dv/brd_master_model.sv ====
// Model of a bus master issuing decode requests and remap commands
`timescale 1ns/1ps
`default_nettype none
module brd_master_model (
  input  wire logic        clk,   // Clock
  input  wire logic        go,    // Issue one request
  input  wire logic [2:0]  mst,   // Master number
  input  wire logic [31:0] adr,   // Address
  input  wire logic [5:0]  cmd,   // Remap command bits
  output brd_pkg::brd_req_s req,  // Request to decoder
  output logic [5:0]       rmp    // Remap bits
);
  always_ff @(posedge clk) begin
    req.valid <= go;
    req.master <= mst;
    // Idle address inverted so a stale value never matches
    req.addr <= go ? adr : ~adr;
    rmp <= cmd;
  end
endmodule
`default_nettype wire

// ==== dv/brd_decoder_asserts.sv ====
// Checker: timing and routing properties of the decoder
`timescale 1ns/1ps
`default_nettype none
module brd_decoder_asserts #(
  parameter int NUM_MST = brd_pkg::NUM_MST
) (
  input wire logic                clk,         // Clock
  input wire logic                srst,        // Reset
  input wire logic [NUM_MST-1:0]  per_master_remap_bit, // Remap
  input wire logic                tcm_cfg_we,  // Size load
  input wire brd_pkg::brd_tcm_s   tcm_size_config, // New sizes
  input wire brd_pkg::brd_req_s   req,         // Request
  input wire brd_pkg::brd_route_s route,       // Route
  input wire logic                route_valid, // Valid
  input wire logic                bus_error,   // Error
  input wire logic                boot_sel_cap, // Strap
  input wire brd_pkg::brd_tcm_s   tcm_size     // Sizes
);
  logic [1:0] run; // Saturates once requests are taken
  always_ff @(posedge clk) begin
    if (srst) run <= 2'h0;
    else if (run != 2'h3) run <= run + 2'h1;
  end
  logic [2:0] gen_n; // 16 KB blocks left to the general area
  assign gen_n = 3'd4 - {1'b0, tcm_size.instruction_coupled_area_size} - {1'b0, tcm_size.data_coupled_area_size};
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_take; req.valid && run == 2'h3; endsequence
  sequence s_alias; s_take ##0 req.addr[31:20] == 12'h000; endsequence
  ans_a: assert property (s_take |=> route_valid) else $error("no answer");
  cause_a: assert property (route_valid |-> $past(req.valid)) else $error("stray");
  err_a: assert property (
    bus_error == (route_valid && route.target == brd_pkg::BRD_T_ERR)) else $error("error flag");
  ext_a: assert property (route_valid && $past(req.addr[31:28]) inside {[4'h1:4'h8]} |->
    route.target == brd_pkg::BRD_T_EXT && route.ext_bank == $past(req.addr[31:28]))
    else $error("ext bank");
  per_a: assert property (route_valid && $past(req.addr[31:28]) == 4'hf |->
    route.target == brd_pkg::BRD_T_PERIPH) else $error("periph bank");
  rom_a: assert property (s_take ##0 req.addr[31:15] == 17'h0080 |=>
    route.target == brd_pkg::BRD_T_ROM) else $error("rom base");
  strap_a: assert property (run == 2'h3 |-> $stable(boot_sel_cap)) else $error("strap");
  size0_a: assert property ($fell(srst) |-> tcm_size == 4'h0) else $error("sizes");
  load_a: assert property (tcm_cfg_we && run == 2'h3 |=>
    tcm_size.instruction_coupled_area_size == (($past(tcm_size_config.instruction_coupled_area_size) == 2'h3) ? brd_pkg::SZ_32K
                           : $past(tcm_size_config.instruction_coupled_area_size))
    && tcm_size.data_coupled_area_size == (($past(tcm_size_config.data_coupled_area_size) == 2'h3) ? brd_pkg::SZ_32K
                              : $past(tcm_size_config.data_coupled_area_size))) else $error("size load");
  remap_a: assert property (s_alias ##0 req.master[2:1] == 2'h2 &&
    per_master_remap_bit[req.master] && req.addr[19:16] == 4'h0
    && {1'b0, req.addr[15:14]} < gen_n |=> route.target == brd_pkg::BRD_T_RAM)
    else $error("remap");
  dma_a: assert property (s_alias ##0 !req.master[2] |=>
    route.target != brd_pkg::BRD_T_RAM) else $error("dma alias");
endmodule
bind brd_decoder brd_decoder_asserts #(.NUM_MST(NUM_MST)) u_brd_decoder_asserts (
  .clk(clk), .srst(srst), .per_master_remap_bit(per_master_remap_bit), .tcm_cfg_we(tcm_cfg_we),
  .tcm_size_config(tcm_size_config), .req(req), .route(route), .route_valid(route_valid),
  .bus_error(bus_error), .boot_sel_cap(boot_sel_cap), .tcm_size(tcm_size));
`default_nettype wire

// ==== dv/boot_remap_address_decoder_tb.sv ====
// Testbench: boot alias, remap, bank and coupled area decoding
`timescale 1ns/1ps
`default_nettype none
module boot_remap_address_decoder_tb;
  logic clk, srst, pin, go, we, rv, berr, cap;
  logic [2:0] mst;
  logic [31:0] adr;
  logic [5:0] cmd, rmp;
  brd_pkg::brd_tcm_s cfg, tsz;
  brd_pkg::brd_req_s req;
  brd_pkg::brd_route_s route;
  brd_pkg::brd_smc_s static_mem_ctrl;
  int miscompares = 0;
  int total_checks = 0;
  brd_master_model u_brd_master_model (.clk(clk), .go(go), .mst(mst), .adr(adr), .cmd(cmd),
    .req(req), .rmp(rmp));
  brd_decoder u_brd_decoder (.clk(clk), .srst(srst), .boot_select_pin(pin),
    .per_master_remap_bit(rmp), .tcm_cfg_we(we), .tcm_size_config(cfg), .req(req),
    .route(route), .route_valid(rv), .bus_error(berr), .boot_sel_cap(cap), .tcm_size(tsz),
    .smc_boot_cfg(static_mem_ctrl));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic do_reset(input logic p);
    @(posedge clk);
    srst <= 1'b1;
    pin <= p;
    cmd <= 6'h00;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    repeat (4) @(posedge clk);
    check(cap, p);
    check(tsz, 4'h0);
  endtask
  // Request, then judge the answer one cycle after it is taken
  task automatic send(input logic [2:0] m, input logic [31:0] a, input brd_pkg::brd_target_e t,
                      input logic [3:0] b);
    @(posedge clk);
    go <= 1'b1;
    mst <= m;
    adr <= a;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    #1;
    check(rv, 1'b1);
    check(route.target, t);
    check(route.offset, a[15:0]);
    check(berr, t == brd_pkg::BRD_T_ERR);
    if (t == brd_pkg::BRD_T_RAM) check(route.ram_block, b[1:0]);
    if (t == brd_pkg::BRD_T_EXT) check(route.ext_bank, b);
  endtask
  task automatic test_boot_rom;
    do_reset(1'b1);
    pin <= 1'b0;
    send(3'h0, 32'h0000_0100, brd_pkg::BRD_T_ROM, 4'h0);
    send(3'h4, 32'h000F_FFFC, brd_pkg::BRD_T_ROM, 4'h0);
    send(3'h1, 32'h0040_7FFC, brd_pkg::BRD_T_ROM, 4'h0);
    send(3'h1, 32'h0040_8000, brd_pkg::BRD_T_ERR, 4'h0);
    send(3'h2, 32'h0030_0000, brd_pkg::BRD_T_RAM, 4'h3);
    send(3'h3, 32'h0030_C004, brd_pkg::BRD_T_RAM, 4'h0);
    send(3'h0, 32'h0010_0000, brd_pkg::BRD_T_ERR, 4'h0);
    send(3'h0, 32'h1000_0000, brd_pkg::BRD_T_EXT, 4'h1);
    send(3'h0, 32'h8FFF_FFFC, brd_pkg::BRD_T_EXT, 4'h8);
    send(3'h0, 32'h9000_0000, brd_pkg::BRD_T_ERR, 4'h0);
    send(3'h0, 32'hFFFF_C000, brd_pkg::BRD_T_PERIPH, 4'h0);
    check(cap, 1'b1);
    $display("test_boot_rom done");
  endtask
  task automatic test_remap;
    @(posedge clk);
    cmd <= 6'h3F;
    send(3'h4, 32'h0000_0000, brd_pkg::BRD_T_RAM, 4'h3);
    send(3'h5, 32'h0000_C000, brd_pkg::BRD_T_RAM, 4'h0);
    send(3'h0, 32'h0000_0000, brd_pkg::BRD_T_ROM, 4'h0);
    send(3'h5, 32'h0040_0000, brd_pkg::BRD_T_ROM, 4'h0);
    @(posedge clk);
    cmd <= 6'h20;
    send(3'h4, 32'h0000_0000, brd_pkg::BRD_T_ROM, 4'h0);
    $display("test_remap done");
  endtask
  task automatic test_tcm;
    logic [3:0] g;
    for (int i = 0; i < 3; i++) begin
      for (int d = 0; d < 3; d++) begin
        @(posedge clk);
        we <= 1'b1;
        cfg <= {2'(i), 2'(d)};
        @(posedge clk);
        we <= 1'b0;
        // Highest free block opens the general area
        g = d == 0 ? 4'h3 : d == 1 ? 4'h2 : i == 0 ? 4'h1 : 4'h0;
        send(3'h4, 32'h0030_0000, (i == 2 && d == 2) ? brd_pkg::BRD_T_ERR : brd_pkg::BRD_T_RAM,
             g);
        send(3'h5, 32'h0010_4000, i == 2 ? brd_pkg::BRD_T_RAM : brd_pkg::BRD_T_ERR, 4'h0);
        send(3'h0, 32'h0020_0000, d > 0 ? brd_pkg::BRD_T_RAM : brd_pkg::BRD_T_ERR, 4'h3);
      end
    end
    // Reserved size code must clamp to 32K
    @(posedge clk);
    we <= 1'b1;
    cfg <= 4'hf;
    @(posedge clk);
    we <= 1'b0;
    @(posedge clk);
    check(tsz, 4'ha);
    $display("test_tcm done");
  endtask
  task automatic test_ext_boot;
    do_reset(1'b0);
    check(static_mem_ctrl, {brd_pkg::SMC_BYTE_SELECT, brd_pkg::SMC_BUS_16, 1'b1});
    send(3'h0, 32'h0000_0000, brd_pkg::BRD_T_EXT, 4'h1);
    send(3'h4, 32'h0030_0000, brd_pkg::BRD_T_RAM, 4'h3);
    $display("test_ext_boot done");
  endtask
  initial begin
    srst = 1'b1;
    pin = 1'b1;
    go = 1'b0;
    we = 1'b0;
    mst = 3'h0;
    adr = 32'h0000_0000;
    cmd = 6'h00;
    cfg = 4'h0;
    test_boot_rom;
    test_remap;
    test_tcm;
    test_ext_boot;
    give_verdict;
  end
  // About twice the expected run length
  initial begin
    repeat (400) @(posedge clk);
    miscompares++;
    give_verdict;
  end
endmodule
`default_nettype wire
